// ### kbd_emu_regs.sv
// Legacy keyboard port emulation register block with AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps

module kbd_emu_regs
	import kbd_emu_pkg::*;
(
	// Clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// AXI4-Lite write
	input  wire logic                 s_axil_awvalid,
	output logic                      s_axil_awready,
	input  wire logic [11:0]          s_axil_awaddr,
	input  wire logic [2:0]           s_axil_awprot,
	input  wire logic                 s_axil_wvalid,
	output logic                      s_axil_wready,
	input  wire logic [31:0]          s_axil_wdata,
	input  wire logic [3:0]           s_axil_wstrb,
	output logic                      s_axil_bvalid,
	input  wire logic                 s_axil_bready,
	output logic [1:0]                s_axil_bresp,
	// AXI4-Lite read
	input  wire logic                 s_axil_arvalid,
	output logic                      s_axil_arready,
	input  wire logic [11:0]          s_axil_araddr,
	input  wire logic [2:0]           s_axil_arprot,
	output logic                      s_axil_rvalid,
	input  wire logic                 s_axil_rready,
	output logic [31:0]               s_axil_rdata,
	output logic [1:0]                s_axil_rresp,
	// Legacy port cycles
	input  kbd_emu_pkg::legacy_req_t  legacy_req,
	output logic                      legacy_ack,
	output logic [7:0]                legacy_rdata,
	// Interrupt
	output logic                      irq
);
	import kbd_emu_pkg::*;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [CTL_WIDTH-1:0] control_reg;
	logic [31:0]          input_reg;
	logic [31:0]          output_reg;
	logic [31:0]          status_reg;
	logic [IRQ_W-1:0]     irq_stat_reg;
	logic [IRQ_W-1:0]     irq_en_reg;
	logic [1:0]           bresp_reg;
	reg_wr_t              wr;

	// ----------------------------------------------------------------
	// Write channel join
	// ----------------------------------------------------------------
	axil_wr_join u_join (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awvalid (s_axil_awvalid),
		.awready (s_axil_awready),
		.awaddr  (s_axil_awaddr),
		.wvalid  (s_axil_wvalid),
		.wready  (s_axil_wready),
		.wdata   (s_axil_wdata),
		.wstrb   (s_axil_wstrb),
		.bvalid  (s_axil_bvalid),
		.bready  (s_axil_bready),
		.wr      (wr)
	);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire sel_ctl = wr.addr == OFF_EMULATION_CONTROL;
	wire sel_in  = wr.addr == OFF_EMULATED_INPUT_BUFFER;
	wire sel_out = wr.addr == OFF_EMULATED_OUTPUT_BUFFER;
	wire sel_st  = wr.addr == OFF_EMULATED_STATUS;
	wire sel_icl = wr.addr == OFF_IRQ_CLEAR;
	wire sel_ien = wr.addr == OFF_IRQ_ENABLE;
	wire wr_hit  = sel_ctl | sel_in | sel_out | sel_st | sel_icl | sel_ien;
	wire wr_ctl  = wr.we & sel_ctl;
	wire wr_in   = wr.we & sel_in;
	wire wr_out  = wr.we & sel_out;
	wire wr_st   = wr.we & sel_st;
	wire wr_icl  = wr.we & sel_icl;
	wire wr_ien  = wr.we & sel_ien;

	// ----------------------------------------------------------------
	// Byte-lane merges
	// ----------------------------------------------------------------
	logic [31:0] ctl_m;
	logic [31:0] in_m;
	logic [31:0] out_m;
	logic [31:0] st_m;
	logic [31:0] ien_m;
	wire  [31:0] ctl_wide = {{(32-CTL_WIDTH){1'b0}}, control_reg};
	wire  [31:0] ien_wide = {{(32-IRQ_W){1'b0}}, irq_en_reg};

	byte_merge u_m_ctl (.old_val(ctl_wide),   .new_val(wr.wdata),
	                    .strb(wr.wstrb),      .merged(ctl_m));
	byte_merge u_m_in  (.old_val(input_reg),  .new_val(wr.wdata),
	                    .strb(wr.wstrb),      .merged(in_m));
	byte_merge u_m_out (.old_val(output_reg), .new_val(wr.wdata),
	                    .strb(wr.wstrb),      .merged(out_m));
	byte_merge u_m_st  (.old_val(status_reg), .new_val(wr.wdata),
	                    .strb(wr.wstrb),      .merged(st_m));
	byte_merge u_m_ien (.old_val(ien_wide),   .new_val(wr.wdata),
	                    .strb(wr.wstrb),      .merged(ien_m));

	// ----------------------------------------------------------------
	// Legacy port cycle decode
	// ----------------------------------------------------------------
	// Cycles are ignored while emulation is disabled
	wire emu_on   = control_reg[CTL_ENABLE];
	wire lg_go    = legacy_req.valid & emu_on;
	wire lg_data  = legacy_req.port == PORT_DATA;
	wire lg_cmd   = legacy_req.port == PORT_CMD;
	wire rd_data  = lg_go & ~legacy_req.write & lg_data;
	wire wr_data  = lg_go &  legacy_req.write & lg_data;
	wire wr_cmd   = lg_go &  legacy_req.write & lg_cmd;
	wire rd_cmd   = lg_go & ~legacy_req.write & lg_cmd;

	assign legacy_ack = rd_data | wr_data | wr_cmd | rd_cmd;

	// ----------------------------------------------------------------
	// Next-state of emulation registers
	// ----------------------------------------------------------------
	logic [31:0] input_next;
	logic [31:0] output_next;
	logic [31:0] status_next;

	// Legacy cycle wins over a same-cycle software write to the flags
	always_comb begin
		input_next  = wr_in  ? in_m  : input_reg;
		output_next = wr_out ? out_m : output_reg;
		status_next = wr_st  ? st_m  : status_reg;
		if (rd_data) begin
			status_next[ST_OUT_FULL] = 1'b0;
		end
		if (wr_data) begin
			input_next               = {24'h00_0000, legacy_req.wdata};
			status_next[ST_IN_FULL]  = 1'b1;
			status_next[ST_CMD_DATA] = 1'b0;
		end
		if (wr_cmd) begin
			input_next               = {24'h00_0000, legacy_req.wdata};
			status_next[ST_IN_FULL]  = 1'b0;
			status_next[ST_CMD_DATA] = 1'b1;
		end
	end

	// Legacy read data: port 64h read has no side effect
	wire [7:0] lg_rd_next = rd_data ? output_reg[7:0]
	                      : rd_cmd  ? status_reg[7:0]
	                      : legacy_rdata;

	// ----------------------------------------------------------------
	// Interrupt events: set beats clear
	// ----------------------------------------------------------------
	wire [IRQ_W-1:0] ev      = {wr_cmd, wr_data, rd_data};
	wire [IRQ_W-1:0] clr_bits = wr_icl ? wr.wdata[IRQ_W-1:0]
	                                   : {IRQ_W{1'b0}};
	wire [IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~clr_bits) | ev;

	assign irq = |(irq_stat_reg & irq_en_reg);

	// ----------------------------------------------------------------
	// Register update
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control_reg  <= '0;
			input_reg    <= RST_ZERO;
			output_reg   <= RST_ZERO;
			status_reg   <= RST_ZERO;
			irq_stat_reg <= '0;
			irq_en_reg   <= '0;
			legacy_rdata <= 8'h00;
			bresp_reg    <= RESP_OKAY;
		end else begin
			if (wr_ctl) begin
				control_reg <= ctl_m[CTL_WIDTH-1:0];
			end
			if (wr_ien) begin
				irq_en_reg <= ien_m[IRQ_W-1:0];
			end
			if (wr.we) begin
				bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			input_reg    <= input_next;
			output_reg   <= output_next;
			status_reg   <= status_next;
			irq_stat_reg <= irq_stat_next;
			legacy_rdata <= lg_rd_next;
		end
	end

	assign s_axil_bresp = bresp_reg;

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	wire ar_take = s_axil_arvalid & s_axil_arready;
	assign s_axil_arready = ~s_axil_rvalid;

	// Control readback reports live flags in bits 10:8
	wire [31:0] ctl_rd = {16'h0000, 5'h00, status_reg[ST_CMD_DATA],
	                      status_reg[ST_IN_FULL], status_reg[ST_OUT_FULL],
	                      control_reg};

	logic [31:0] rd_mux;
	logic        rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		unique case (s_axil_araddr)
			OFF_EMULATION_CONTROL:      rd_mux = ctl_rd;
			OFF_EMULATED_INPUT_BUFFER:  rd_mux = input_reg;
			OFF_EMULATED_OUTPUT_BUFFER: rd_mux = output_reg;
			OFF_EMULATED_STATUS:        rd_mux = status_reg;
			OFF_IRQ_STATUS: rd_mux = {{(32-IRQ_W){1'b0}}, irq_stat_reg};
			OFF_IRQ_ENABLE: rd_mux = {{(32-IRQ_W){1'b0}}, irq_en_reg};
			default: begin
				rd_mux = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axil_rvalid <= 1'b0;
			s_axil_rdata  <= 32'h0000_0000;
			s_axil_rresp  <= RESP_OKAY;
		end else if (ar_take) begin
			s_axil_rvalid <= 1'b1;
			s_axil_rdata  <= rd_mux;
			s_axil_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axil_rready) begin
			s_axil_rvalid <= 1'b0;
		end
	end

endmodule : kbd_emu_regs

// ### kbd_emu_pkg.sv
// Package: register map, field layout and carrier types for keyboard emulation
package kbd_emu_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_EMULATION_CONTROL      = 12'h100;
	localparam logic [11:0] OFF_EMULATED_INPUT_BUFFER  = 12'h104;
	localparam logic [11:0] OFF_EMULATED_OUTPUT_BUFFER = 12'h108;
	localparam logic [11:0] OFF_EMULATED_STATUS        = 12'h10C;
	localparam logic [11:0] OFF_IRQ_STATUS             = 12'h110;
	localparam logic [11:0] OFF_IRQ_CLEAR              = 12'h114;
	localparam logic [11:0] OFF_IRQ_ENABLE             = 12'h118;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int          ST_OUT_FULL  = 0;
	localparam int          ST_IN_FULL   = 1;
	localparam int          ST_CMD_DATA  = 3;
	localparam int          CTL_ENABLE   = 0;
	localparam int          CTL_WIDTH    = 8;
	localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
	localparam logic [7:0]  PORT_DATA    = 8'h60;
	localparam logic [7:0]  PORT_CMD     = 8'h64;
	localparam int          IRQ_W        = 3;
	localparam int          IRQ_RD_DATA  = 0;
	localparam int          IRQ_WR_DATA  = 1;
	localparam int          IRQ_WR_CMD   = 2;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] port;
		logic [7:0] wdata;
	} legacy_req_t;

	typedef struct packed {
		logic        we;
		logic [11:0] addr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
	} reg_wr_t;

endpackage : kbd_emu_pkg

// ### axil_wr_join.sv
// Write address and data joiner for the AXI4-Lite slave
`timescale 1ns/1ps
module axil_wr_join
	import kbd_emu_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// Address and data channels
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [11:0]       awaddr,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	// Response channel
	output logic                   bvalid,
	input  wire logic              bready,
	// Joined write
	output kbd_emu_pkg::reg_wr_t   wr
);
	// ----------------------------------------------------------------
	// Capture each channel; either order accepted
	// ----------------------------------------------------------------
	logic        aw_have_reg;
	logic        w_have_reg;
	logic [11:0] addr_reg;
	logic [31:0] data_reg;
	logic [3:0]  strb_reg;
	wire         aw_take = awvalid & awready;
	wire         w_take  = wvalid & wready;
	wire         fire    = aw_have_reg & w_have_reg & ~bvalid;

	assign awready  = ~aw_have_reg & ~bvalid;
	assign wready   = ~w_have_reg & ~bvalid;
	assign wr.we    = fire;
	assign wr.addr  = addr_reg;
	assign wr.wdata = data_reg;
	assign wr.wstrb = strb_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			bvalid      <= 1'b0;
			addr_reg    <= 12'h000;
			data_reg    <= 32'h0000_0000;
			strb_reg    <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_have_reg <= 1'b1;
				addr_reg    <= awaddr;
			end
			if (w_take) begin
				w_have_reg <= 1'b1;
				data_reg   <= wdata;
				strb_reg   <= wstrb;
			end
			if (fire) begin
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
				bvalid      <= 1'b1;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end
endmodule : axil_wr_join

// ### byte_merge.sv
// Byte-enable merge of a 32-bit register word
`timescale 1ns/1ps
module byte_merge (
	// Old word and write
	input  wire logic [31:0] old_val,
	input  wire logic [31:0] new_val,
	input  wire logic [3:0]  strb,
	// Merged word
	output logic      [31:0] merged
);
	// ----------------------------------------------------------------
	// One lane per byte
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_lane
			assign merged[i*8 +: 8] = strb[i] ? new_val[i*8 +: 8]
			                                  : old_val[i*8 +: 8];
		end
	endgenerate
endmodule : byte_merge

// ### kbd_emu_asserts.sv
// Port checks for the legacy keyboard emulation block
`timescale 1ns/1ps
module kbd_emu_asserts
	import kbd_emu_pkg::*;
(
	// Clock and reset
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// Register bus
	input  wire logic               s_axil_awvalid,
	input  wire logic               s_axil_awready,
	input  wire logic [11:0]        s_axil_awaddr,
	input  wire logic               s_axil_wvalid,
	input  wire logic               s_axil_wready,
	input  wire logic               s_axil_bvalid,
	input  wire logic [1:0]         s_axil_bresp,
	input  wire logic               s_axil_arvalid,
	input  wire logic               s_axil_arready,
	input  wire logic               s_axil_rvalid,
	// Legacy side
	input  kbd_emu_pkg::legacy_req_t legacy_req,
	input  wire logic               legacy_ack,
	input  wire logic [7:0]         legacy_rdata,
	input  wire logic               irq
);
	// ----
	// Checks
	// ----
	logic lw;
	logic ld;
	assign lw = legacy_req.write;
	assign ld = legacy_req.port == PORT_DATA;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	out_clear_a: assert property (
		legacy_ack && !lw && ld ##1 legacy_ack && !lw && !ld
		|=> !legacy_rdata[ST_OUT_FULL])
		else $error("output-full flag not cleared");
	data_write_a: assert property (
		legacy_ack && lw && ld ##1 legacy_ack && !lw && !ld
		|=> legacy_rdata[ST_IN_FULL] && !legacy_rdata[ST_CMD_DATA])
		else $error("data write flags wrong");
	cmd_write_a: assert property (
		legacy_ack && lw && !ld ##1 legacy_ack && !lw && !ld
		|=> !legacy_rdata[ST_IN_FULL] && legacy_rdata[ST_CMD_DATA])
		else $error("command write flags wrong");
	stat_hold_a: assert property (
		legacy_ack && !lw && !ld ##1 legacy_ack && !lw && !ld
		|=> $past(s_axil_bvalid) || $stable(legacy_rdata))
		else $error("status read changed status");
	ack_gate_a: assert property (
		legacy_ack |-> legacy_req.valid
		&& (ld || legacy_req.port == PORT_CMD))
		else $error("ack without a legacy port cycle");
	wr_resp_a: assert property (
		s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready
		&& s_axil_awaddr == OFF_EMULATED_STATUS
		|-> ##2 s_axil_bvalid && s_axil_bresp == RESP_OKAY)
		else $error("status write response wrong");
	rd_resp_a: assert property (
		s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
		else $error("read response late");
	reset_quiet_a: assert property (
		$rose(aresetn) |-> !s_axil_bvalid && !s_axil_rvalid && !irq)
		else $error("outputs active after reset");
endmodule : kbd_emu_asserts

bind kbd_emu_regs kbd_emu_asserts chk_i (
	.aclk(aclk), .aresetn(aresetn), .s_axil_awvalid(s_axil_awvalid),
	.s_axil_awready(s_axil_awready), .s_axil_awaddr(s_axil_awaddr),
	.s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
	.s_axil_bvalid(s_axil_bvalid), .s_axil_bresp(s_axil_bresp),
	.s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
	.s_axil_rvalid(s_axil_rvalid), .legacy_req(legacy_req),
	.legacy_ack(legacy_ack), .legacy_rdata(legacy_rdata), .irq(irq)
);

// ### legacy_host.sv
// Model of the host issuing legacy port cycles
`timescale 1ns/1ps
module legacy_host
	import kbd_emu_pkg::*;
(
	// Clock
	input  wire logic               aclk,
	// Legacy cycle
	output kbd_emu_pkg::legacy_req_t req,
	input  wire logic               ack,
	input  wire logic [7:0]         rdata
);
	// One cycle per call; r is the answer to the previous read
	task automatic cyc(input logic w, input logic [7:0] p, input logic [7:0] d,
		output logic a, output logic [7:0] r);
		@(posedge aclk);
		req <= '{1'b1, w, p, d};
		#1;
		a = ack;
		r = rdata;
	endtask : cyc
	// Idle lines flip, so no stale address can pass for a cycle
	task automatic idle(output logic [7:0] r);
		@(posedge aclk);
		req <= '{1'b0, req.write, ~req.port, ~req.wdata};
		#1;
		r = rdata;
	endtask : idle
	initial req = '0;
endmodule : legacy_host

// ### kbd_emu_regs_tb.sv
// Self-checking bench for the legacy keyboard emulation block
`timescale 1ns/1ps
module kbd_emu_regs_tb;
	import kbd_emu_pkg::*;
	typedef struct {
		logic [11:0] ad;
		logic [31:0] wd;
		logic [3:0]  sb;
		logic [31:0] rd;
		logic [1:0]  rs;
	} row_t;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, ack, irq, a;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, e;
	logic [7:0] lrdata, r;
	legacy_req_t req;
	int fail_count, comparisons;
	row_t rows [5] = '{
		'{OFF_EMULATION_CONTROL, 32'h0000_0001, 4'hF, 32'h0000_0001, RESP_OKAY},
		'{OFF_EMULATED_INPUT_BUFFER, 32'h0000_00A5, 4'hF, 32'h0000_00A5, 2'h0},
		'{OFF_EMULATED_OUTPUT_BUFFER, 32'h0000_005C, 4'hF, 32'h0000_005C, 2'h0},
		'{OFF_EMULATED_STATUS, 32'hFFFF_FF01, 4'h1, 32'h0000_0001, RESP_OKAY},
		'{12'h1F0, 32'h1234_5678, 4'hF, 32'h0000_0000, RESP_SLVERR}};

	kbd_emu_regs uut (.aclk(aclk), .aresetn(aresetn),
		.s_axil_awvalid(awvalid), .s_axil_awready(awready),
		.s_axil_awaddr(awaddr), .s_axil_awprot(3'h0), .s_axil_wvalid(wvalid),
		.s_axil_wready(wready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
		.s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_bresp(bresp),
		.s_axil_arvalid(arvalid), .s_axil_arready(arready),
		.s_axil_araddr(araddr), .s_axil_arprot(3'h0), .s_axil_rvalid(rvalid),
		.s_axil_rready(rready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
		.legacy_req(req), .legacy_ack(ack), .legacy_rdata(lrdata), .irq(irq));
	legacy_host host (.aclk(aclk), .req(req), .ack(ack), .rdata(lrdata));

	// ----
	// Bus tasks
	// ----
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Handshakes judged on settled values, so no race with the edge
	task automatic wr(input logic [11:0] ad, input logic [31:0] dt,
		input logic [3:0] sb, output logic [1:0] rs);
		int n;
		logic ah, wh, bh;
		n = 0;
		bh = 1'b0;
		@(posedge aclk);
		awaddr <= ad;
		wdata <= dt;
		wstrb <= sb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid;
			rs = bresp;
			@(posedge aclk);
			n++;
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end while (!bh && n < 64);
		bready <= 1'b0;
		if (n >= 64) fail_count++;
	endtask : wr
	task automatic rd(input logic [11:0] ad, output logic [31:0] dt,
		output logic [1:0] rs);
		int n;
		logic ah, rh;
		n = 0;
		rh = 1'b0;
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ah = arvalid & arready;
			rh = rvalid;
			dt = rdata;
			rs = rresp;
			@(posedge aclk);
			n++;
			if (ah) arvalid <= 1'b0;
		end while (!rh && n < 64);
		rready <= 1'b0;
		if (n >= 64) fail_count++;
	endtask : rd
	task end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// Run needs about a hundred cycles; a hang is cut well beyond
	initial begin
		#40000;
		fail_count++;
		end_sim;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		fail_count = 0;
		comparisons = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_EMULATED_STATUS, d, e);
		chk({e, d}, 34'h0);
		foreach (rows[i]) begin
			wr(rows[i].ad, rows[i].wd, rows[i].sb, e);
			chk({32'h0, e}, {32'h0, rows[i].rs});
			rd(rows[i].ad, d, e);
			chk({e, d}, {rows[i].rs, rows[i].rd});
		end
		// Output buffer loaded above, out-full set by software
		host.cyc(1'b0, PORT_DATA, 8'h00, a, r);
		chk({33'h0, a}, 34'h1);
		host.cyc(1'b0, PORT_CMD, 8'h00, a, r);
		chk({26'h0, r}, 34'h5C);
		host.cyc(1'b1, PORT_DATA, 8'h3C, a, r);
		chk({26'h0, r}, 34'h0);
		host.cyc(1'b0, PORT_CMD, 8'h00, a, r);
		host.cyc(1'b1, PORT_CMD, 8'hC3, a, r);
		chk({26'h0, r}, 34'h2);
		host.cyc(1'b0, PORT_CMD, 8'h00, a, r);
		host.cyc(1'b0, PORT_CMD, 8'h00, a, r);
		chk({26'h0, r}, 34'h8);
		host.idle(r);
		chk({26'h0, r}, 34'h8);
		rd(OFF_EMULATED_INPUT_BUFFER, d, e);
		chk({e, d}, 34'hC3);
		rd(OFF_EMULATION_CONTROL, d, e);
		chk({e, d}, 34'h401);
		rd(OFF_IRQ_STATUS, d, e);
		chk({e, d}, 34'h7);
		wr(OFF_IRQ_ENABLE, 32'h0000_0002, 4'hF, e);
		chk({33'h0, irq}, 34'h1);
		wr(OFF_IRQ_ENABLE, 32'h0000_0000, 4'hF, e);
		chk({33'h0, irq}, 34'h0);
		wr(OFF_IRQ_ENABLE, 32'h0000_0002, 4'hF, e);
		wr(OFF_IRQ_CLEAR, 32'h0000_0002, 4'hF, e);
		chk({33'h0, irq}, 34'h0);
		rd(OFF_IRQ_STATUS, d, e);
		chk({e, d}, 34'h5);
		// Emulation off: port cycles must be ignored
		wr(OFF_EMULATION_CONTROL, 32'h0000_0000, 4'hF, e);
		host.cyc(1'b1, PORT_DATA, 8'h11, a, r);
		chk({33'h0, a}, 34'h0);
		host.idle(r);
		rd(OFF_EMULATED_STATUS, d, e);
		chk({e, d}, 34'h8);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_EMULATED_STATUS, d, e);
		chk({e, d}, 34'h0);
		end_sim;
	end
endmodule : kbd_emu_regs_tb
